//--- core/psu_cmd_pkg.sv
/*
  Shared constants, types and helpers for the regulation command bank.
  Assumes one 100 MHz clock and a two-wire serial bus at the pins.
*/
package psu_cmd_pkg;
  // ====================================
  // Bus address and command map
  localparam logic [6:0] DEV_ADDR = 7'h18;
  localparam logic [7:0] CMD_VOLT_ONLY = 8'h0E;
  localparam logic [7:0] CMD_CV = 8'h10;
  localparam logic [7:0] CMD_CDC = 8'h16;
  localparam logic [7:0] CMD_KNEE = 8'h1A;
  localparam logic [7:0] CMD_PLT = 8'h2A;
  localparam logic [7:0] CMD_RD_PTR = 8'h80;
  localparam logic [7:0] CMD_CC = 8'h98;
  localparam logic [7:0] CMD_OL_RESP = 8'hA8;
  // Readback pointer targets and status bit positions
  localparam logic [7:0] PTR_STATUS = 8'h14;
  localparam logic [7:0] PTR_AVG_CUR = 8'h1A;
  localparam int BIT_READY = 14;
  localparam int BIT_IS_SHORT = 3;
  localparam int BIT_UV = 1;
  // ====================================
  // Reset values and legal ranges
  localparam logic [13:0] CV_RESET = 14'h01F4;
  localparam logic [13:0] CV_MIN = 14'h012C;
  localparam logic [13:0] CV_MAX = 14'h0960;
  localparam logic [7:0] CC_RESET = 8'h80;
  localparam logic [7:0] CC_MIN = 8'h19;
  localparam logic [7:0] CC_MAX = 8'h80;
  localparam logic [7:0] KNEE_RESET = 8'hF0;
  localparam logic [7:0] KNEE_MAX = 8'hF0;
  localparam logic [3:0] CDC_MAX = 4'hC;
  localparam logic [14:0] CDC_STEP = 15'h0005;
  localparam logic [19:0] POWER_SCALE = 20'h0_0500;
  localparam logic [11:0] KNEE_TO_10MV = 12'h00A;
  localparam logic [7:0] FULL_SCALE = 8'h80;
  localparam logic [6:0] PLT_BASE = 7'h08;
  // ====================================
  // Timing
  localparam int MS_US = 1000;
  localparam int CLK_NS = 10;
  localparam int CYC_PER_MS = MS_US * 1000 / CLK_NS;
  // ====================================
  // Types
  typedef enum logic [1:0] {RESP_NONE = 2'b00, RESP_AR = 2'b01, RESP_LO = 2'b10} resp_e;
  typedef enum logic [1:0] {REG_CV = 2'b00, REG_CP = 2'b01, REG_CC = 2'b10} region_e;
  typedef struct packed {
    logic valid;
    logic first;
    logic [7:0] data;
  } byte_ev_s;
  typedef struct packed {
    logic voltage_only_enable;
    logic [13:0] cv;
    logic [3:0] cdc;
    logic [7:0] knee;
    logic [1:0] plt;
    logic [7:0] ptr;
    logic [7:0] cc;
    resp_e resp;
  } cmd_regs_s;
  // Odd parity holds when the byte has an odd count of ones
  function automatic logic odd_par(input logic [7:0] b);
    return ^b;
  endfunction
endpackage

//--- core/psu_regulation_command_regs.sv
/*
  Command register bank setting the regulation targets of the supply,
  reached over the two-wire bus, plus the overload timer and region select.
  Assumes averaged current, output voltage and fault inputs synchronous to CLK.
*/
`timescale 1ns/10ps
// Overview of operation
// R1: Host checks ready flag before traffic and after any restart or power-up.
// R2: Pointer 0x14 written to 0x80; high byte read back; bit 14 means ready.
// R3: Current regulation compares the averaged current reading, never instant samples.
// R4: Output setpoint spans 3 V to 24 V at 10 mV per step.
// R5: Output setpoint resets to 5 V.
// R6: Command bytes carry odd parity in the top bit; current register is 0x98.
// R7: Current threshold code limited to 25 through 128.
// R8: One code step is full-scale sense voltage divided by 128.
// R9: Knee voltage times full-scale current sets the power limit.
// R10: Regions go voltage, then power, then current below the knee voltage.
// R11: Knee voltage at 24 V removes the constant-power region.
// R12: Lowering current threshold leaves the power limit unchanged.
// R13: Cable drop code 0 to 12 gives 0 to 600 mV in 50 mV steps.
// R14: Compensation zero at no load, linear, full at full-scale current.
// R15: Shorted sense input disables compensation and current regulation.
// R16: Voltage-only mode turns the current register into an overload threshold.
// R17: Overload starts peak-load timer of 8, 16, 32 or 64 ms.
// R18: Timer expiry gives auto-restart, latch-off or nothing; code 2 latches.
// R19: After reset fault response is none and timer is 8 ms.
// R20: Undervoltage protection stays forced on in voltage-only mode.
// R21: Address byte 0x30 writes, 0x31 reads; words go command, low, high.
module psu_regulation_command_regs
  import psu_cmd_pkg::*;
#(
  parameter int MS_CYCLES = CYC_PER_MS
)(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // Serial bus pins
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // Supply measurements and status
  input wire logic SYS_READY,
  input wire logic [7:0] AVG_CURRENT,
  input wire logic [11:0] OUT_VOLTAGE,
  input wire logic IS_SHORT,
  input wire logic UV_COMPARE,
  // Regulation targets
  output logic [13:0] CV_TARGET,
  output logic CC_REG_EN,
  output logic [7:0] CC_LIMIT,
  output logic [6:0] CDC_OFFSET,
  output region_e REGION,
  // Overload handling
  output logic OVERLOAD,
  output logic AUTO_RESTART,
  output logic LATCH_OFF,
  output logic UV_PROTECT_FORCE
);
  localparam int MSW = $clog2(MS_CYCLES);
  localparam logic [MSW-1:0] MS_LAST = MSW'(MS_CYCLES - 1);

  if (MS_CYCLES < 2) begin : g_chk
    $error("MS_CYCLES must be at least 2");
  end

  typedef enum logic [2:0] {
    X_IDLE = 3'b000, X_CMD = 3'b001, X_LO = 3'b010,
    X_HI = 3'b011, X_RD = 3'b100, X_SKIP = 3'b101
  } xfer_e;
  typedef struct packed {
    cmd_regs_s r;
    xfer_e x;
    logic [7:0] cmd;
    logic [7:0] lo;
    logic ack;
    logic rd_hi;
    logic [7:0] tx;
    logic [MSW-1:0] ms;
    logic [6:0] plt_cnt;
    logic over;
    logic fired;
    logic ar;
    logic latched;
    logic cc_en;
    region_e region;
    logic [6:0] cdc_off;
  } st_s;

  st_s s;
  st_s n;
  byte_ev_s rx;
  logic tx_taken;
  logic [15:0] status;
  logic [15:0] rd_word;
  logic over_now;
  logic [19:0] p_meas;
  logic [19:0] p_lim;
  logic [11:0] knee_10mv;
  logic [7:0] avg_sat;
  logic [14:0] cdc_prod;
  logic [6:0] plt_limit;

  // ====================================
  // Helpers
  function automatic logic [13:0] clamp(input logic [13:0] v, input logic [13:0] lo,
                                        input logic [13:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Data length of a command: 0 unknown, 1 byte, 2 word
  function automatic logic [1:0] cmd_len(input logic [7:0] c);
    logic [1:0] l;
    l = 2'h0;
    if (c == CMD_VOLT_ONLY || c == CMD_CDC || c == CMD_PLT || c == CMD_OL_RESP) begin
      l = 2'h1;
    end else if (c == CMD_CV || c == CMD_KNEE || c == CMD_RD_PTR || c == CMD_CC) begin
      l = 2'h2;
    end
    return l;
  endfunction

  // Store a payload; out of range setpoint, drop, knee and threshold codes are clamped, not refused
  function automatic cmd_regs_s apply(input cmd_regs_s r, input logic [7:0] c,
                                      input logic [13:0] v);
    cmd_regs_s q;
    logic [13:0] t;
    q = r;
    t = 14'h0000;
    case (c)
      // R16: mode select
      CMD_VOLT_ONLY: q.voltage_only_enable = v[0];
      // R4: setpoint range
      CMD_CV: q.cv = clamp(v, CV_MIN, CV_MAX);
      // R13: compensation code
      CMD_CDC: q.cdc = (v > {10'h000, CDC_MAX}) ? CDC_MAX : v[3:0];
      CMD_KNEE: begin
        t = clamp(v, 14'h0000, {6'h00, KNEE_MAX});
        q.knee = t[7:0];
      end
      // R17: timer length code
      CMD_PLT: q.plt = v[1:0];
      CMD_RD_PTR: q.ptr = v[7:0];
      // R7: threshold range
      CMD_CC: begin
        t = clamp(v, {6'h00, CC_MIN}, {6'h00, CC_MAX});
        q.cc = t[7:0];
      end
      // R18: response code, unused code means none
      CMD_OL_RESP: q.resp = (v[1:0] == 2'b11) ? RESP_NONE : resp_e'(v[1:0]);
      default: q = r;
    endcase
    return q;
  endfunction

  // ====================================
  // Bus byte engine
  serial_byte_link u_link (
    .clk(CLK),
    .rst_b(RST_B),
    .scl(SCL),
    .sda_in(SDA_IN),
    .sda_oe(SDA_OE),
    .ack(s.ack),
    .tx_data(s.tx),
    .rx(rx),
    .tx_taken(tx_taken)
  );

  // R2: live status word and readback choice
  always_comb begin
    status = 16'h0000;
    status[BIT_READY] = SYS_READY;
    status[BIT_IS_SHORT] = IS_SHORT;
    status[BIT_UV] = UV_COMPARE;
    if (s.r.ptr == PTR_STATUS) begin
      rd_word = status;
    end else if (s.r.ptr == PTR_AVG_CUR) begin
      rd_word = {8'h00, AVG_CURRENT};
    end else begin
      rd_word = 16'h0000;
    end
  end

  // ====================================
  // Next state: transactions, regulation, overload timer
  always_comb begin
    n = s;
    n.ar = 1'b0;
    // R21: address byte, then command, low, high
    if (rx.valid && rx.first) begin
      n.ack = (rx.data[7:1] == DEV_ADDR);
      n.x = !n.ack ? X_IDLE : (rx.data[0] ? X_RD : X_CMD);
      n.tx = rd_word[7:0];
      n.rd_hi = 1'b1;
    end else if (rx.valid) begin
      case (s.x)
        X_CMD: begin
          // R6: command parity and known command code
          n.ack = odd_par(rx.data) && (cmd_len(rx.data) != 2'h0);
          n.cmd = rx.data;
          n.x = n.ack ? X_LO : X_SKIP;
        end
        X_LO: begin
          n.ack = 1'b1;
          n.lo = rx.data;
          if (cmd_len(s.cmd) == 2'h1) begin
            n.r = apply(s.r, s.cmd, {6'h00, rx.data});
            n.x = X_SKIP;
          end else begin
            n.x = X_HI;
          end
        end
        X_HI: begin
          // R6: word bytes carry parity, pointer word excepted
          n.ack = (s.cmd == CMD_RD_PTR) || (odd_par(s.lo) && odd_par(rx.data));
          if (n.ack) n.r = apply(s.r, s.cmd, {rx.data[6:0], s.lo[6:0]});
          n.x = X_SKIP;
        end
        default: n.ack = 1'b0;
      endcase
    end
    // R21: read returns low byte then high byte
    if (tx_taken) begin
      n.tx = s.rd_hi ? rd_word[15:8] : rd_word[7:0];
      n.rd_hi = !s.rd_hi;
    end

    // R15: shorted sense kills current regulation
    n.cc_en = !s.r.voltage_only_enable && !IS_SHORT;
    // R16: threshold becomes an overload level
    over_now = s.r.voltage_only_enable && (AVG_CURRENT > s.r.cc);
    // R9: power measured against knee times full scale
    // R12: limit ignores the current code
    p_meas = {8'h00, OUT_VOLTAGE} * {12'h000, AVG_CURRENT};
    p_lim = {12'h000, s.r.knee} * POWER_SCALE;
    knee_10mv = {4'h0, s.r.knee} * KNEE_TO_10MV;
    // R3: regions use the averaged current only
    // R11: knee at max skips power region
    if (IS_SHORT) begin
      n.region = REG_CV;
    end else if (n.cc_en && AVG_CURRENT >= s.r.cc) begin
      n.region = REG_CC;
    end else if (s.r.knee < KNEE_MAX && p_meas >= p_lim) begin
      // R10: power limit above knee, current limit below it
      n.region = (OUT_VOLTAGE >= knee_10mv) ? REG_CP : REG_CC;
    end else begin
      n.region = REG_CV;
    end
    // R14: compensation linear up to full-scale current
    // R8: codes count 128ths of full scale
    avg_sat = (AVG_CURRENT > FULL_SCALE) ? FULL_SCALE : AVG_CURRENT;
    cdc_prod = {11'h000, s.r.cdc} * CDC_STEP * {7'h00, avg_sat};
    n.cdc_off = IS_SHORT ? 7'h00 : cdc_prod[13:7];

    // R17: millisecond count runs only while overloaded
    plt_limit = PLT_BASE << s.r.plt;
    n.over = over_now;
    if (!over_now) begin
      n.ms = '0;
      n.plt_cnt = 7'h00;
      n.fired = 1'b0;
    end else if (s.ms == MS_LAST) begin
      n.ms = '0;
      if (!s.fired) begin
        n.plt_cnt = s.plt_cnt + 7'h01;
        if (n.plt_cnt == plt_limit) begin
          // R18: one response per overload episode
          n.fired = 1'b1;
          n.ar = (s.r.resp == RESP_AR);
          n.latched = s.latched || (s.r.resp == RESP_LO);
        end
      end
    end else begin
      n.ms = s.ms + 1'b1;
    end
  end

  // R5: setpoint 5 V after reset
  // R19: no response, 8 ms timer after reset
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      s <= '0;
      s.r.cv <= CV_RESET;
      s.r.cc <= CC_RESET;
      s.r.knee <= KNEE_RESET;
      s.r.ptr <= PTR_STATUS;
    end else begin
      s <= n;
    end
  end

  // Outputs; open drain, so the pin only ever pulls low
  assign SDA_OUT = 1'b0;
  assign CV_TARGET = s.r.cv;
  assign CC_REG_EN = s.cc_en;
  assign CC_LIMIT = s.r.cc;
  assign CDC_OFFSET = s.cdc_off;
  assign REGION = s.region;
  assign OVERLOAD = s.over;
  assign AUTO_RESTART = s.ar;
  assign LATCH_OFF = s.latched;
  // R20: undervoltage guard forced in voltage-only mode
  assign UV_PROTECT_FORCE = s.r.voltage_only_enable;

  // ====================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  property p_cv_range;
    CV_TARGET >= CV_MIN && CV_TARGET <= CV_MAX;
  endproperty
  a_cv_range: assert property (p_cv_range) else $error("setpoint out of range"); // R4

  property p_reset_vals;
    !$past(RST_B) |-> CV_TARGET == CV_RESET && s.r.plt == 2'b00 && s.r.resp == RESP_NONE;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset values"); // R5 R19

  property p_cc_range;
    CC_LIMIT >= CC_MIN && CC_LIMIT <= CC_MAX;
  endproperty
  a_cc_range: assert property (p_cc_range) else $error("threshold out of range"); // R7

  property p_par;
    rx.valid && !rx.first && s.x == X_CMD && !odd_par(rx.data) |=> !s.ack;
  endproperty
  a_par: assert property (p_par) else $error("even parity command accepted"); // R6

  property p_short;
    IS_SHORT |=> CDC_OFFSET == 7'h00 && REGION != REG_CC && !CC_REG_EN;
  endproperty
  a_short: assert property (p_short) else $error("regulation with shorted sense"); // R15

  property p_cdc;
    AVG_CURRENT == 8'h00 |=> CDC_OFFSET == 7'h00 ##0 CDC_OFFSET <= 7'h3C;
  endproperty
  a_cdc: assert property (p_cdc) else $error("compensation at no load"); // R14

  property p_cvo;
    s.r.voltage_only_enable |=> !CC_REG_EN;
  endproperty
  a_cvo: assert property (p_cvo) else $error("current regulation in voltage-only"); // R16

  property p_no_cp;
    s.r.knee == KNEE_MAX |=> REGION != REG_CP;
  endproperty
  a_no_cp: assert property (p_no_cp) else $error("power region with knee at max"); // R11

  property p_latch;
    $rose(LATCH_OFF) |-> $past(s.r.resp) == RESP_LO && $past(OVERLOAD);
  endproperty
  a_latch: assert property (p_latch) else $error("latch-off without cause"); // R18

  property p_ar;
    AUTO_RESTART |-> s.r.resp == RESP_AR && OVERLOAD ##1 !AUTO_RESTART;
  endproperty
  a_ar: assert property (p_ar) else $error("bad auto-restart pulse"); // R18

  c_cv_write: cover property ($changed(CV_TARGET));
  c_read: cover property (tx_taken);
  c_latch: cover property ($rose(LATCH_OFF));
  c_cp: cover property (REGION == REG_CP);
endmodule

//--- core/serial_byte_link.sv
/*
  Byte engine of the two-wire slave: start/stop, bit shifting, ack slot, reads.
  Assumes pins synchronous to CLK, each SCL phase at least four cycles long.
*/
`timescale 1ns/10ps
module serial_byte_link
  import psu_cmd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Pins
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_oe,
  // Bytes to and from the register bank
  input wire logic ack,
  input wire logic [7:0] tx_data,
  output byte_ev_s rx,
  output logic tx_taken
);
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000, PH_RX = 3'b001, PH_ACK = 3'b010,
    PH_TX = 3'b011, PH_MACK = 3'b100, PH_TXL = 3'b101
  } phase_e;
  typedef struct packed {
    logic scl_q;
    logic sda_q;
    phase_e ph;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic first;
    logic rd;
    logic oe;
    logic ev;
    logic taken;
  } link_s;
  link_s s;
  link_s n;
  logic rise;
  logic fall;

  // ====================================
  // Bit level sequencing
  always_comb begin
    n = s;
    n.scl_q = scl;
    n.sda_q = sda_in;
    n.ev = 1'b0;
    n.taken = 1'b0;
    rise = scl && !s.scl_q;
    fall = !scl && s.scl_q;
    if (scl && s.scl_q && s.sda_q && !sda_in) begin
      n.ph = PH_RX;
      n.cnt = 4'h0;
      n.first = 1'b1;
      n.rd = 1'b0;
      n.oe = 1'b0;
    end else if (scl && s.scl_q && !s.sda_q && sda_in) begin
      n.ph = PH_IDLE;
      n.oe = 1'b0;
    end else begin
      case (s.ph)
        PH_RX: if (rise) begin
          n.sh = {s.sh[6:0], sda_in};
          n.cnt = s.cnt + 4'h1;
          if (s.cnt == 4'h7) begin
            n.ev = 1'b1;
            n.ph = PH_ACK;
          end
        end
        PH_ACK: if (fall) begin
          if (!s.oe) begin
            // Bank decided in the meantime; a refusal ends the transfer
            n.oe = ack;
            n.rd = s.first && s.sh[0];
            if (!ack) n.ph = PH_IDLE;
          end else begin
            n.first = 1'b0;
            n.cnt = 4'h0;
            n.oe = s.rd && !tx_data[7];
            n.sh = {tx_data[6:0], 1'b0};
            n.cnt = s.rd ? 4'h1 : 4'h0;
            n.ph = s.rd ? PH_TX : PH_RX;
          end
        end
        PH_TX: if (fall) begin
          n.oe = (s.cnt == 4'h8) ? 1'b0 : !s.sh[7];
          n.sh = {s.sh[6:0], 1'b0};
          n.cnt = s.cnt + 4'h1;
          if (s.cnt == 4'h8) n.ph = PH_MACK;
        end
        PH_MACK: if (rise) begin
          n.taken = !sda_in;
          n.ph = sda_in ? PH_IDLE : PH_TXL;
        end
        PH_TXL: if (fall) begin
          n.oe = !tx_data[7];
          n.sh = {tx_data[6:0], 1'b0};
          n.cnt = 4'h1;
          n.ph = PH_TX;
        end
        default: n.ph = PH_IDLE;
      endcase
    end
  end

  // State register; lines idle high at reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
      s.scl_q <= 1'b1;
      s.sda_q <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign sda_oe = s.oe;
  assign rx = '{valid: s.ev, first: s.first, data: s.sh};
  assign tx_taken = s.taken;
endmodule

//--- verification/host_model.sv
/*
  Bus master model for the command bank: start, stop, byte and word transfers.
  Assumes a pull-up on the data wire and a bench that calls one task at a time.
*/
`timescale 1ns/10ps
module host_model (
  // Clock and wire level
  input wire logic clk,
  input wire logic sda,
  // Driven pins
  output logic scl,
  output logic sda_low
);
  // ========================================
  // Pin timing
  // Idle released; the bus clock stands still outside frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Data moves two cycles after the clock falls, so it never races the edge
  task automatic bit9(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      wt(2);
      sda_low = !tx[i];
      wt(3);
      scl = 1'b1;
      wt(5);
      rx[i] = sda;
      scl = 1'b0;
    end
  endtask
  task automatic start_c();
    wt(2);
    sda_low = 1'b0;
    wt(3);
    scl = 1'b1;
    wt(5);
    sda_low = 1'b1;
    wt(5);
    scl = 1'b0;
  endtask
  task automatic stop_c();
    wt(2);
    sda_low = 1'b1;
    wt(3);
    scl = 1'b1;
    wt(5);
    sda_low = 1'b0;
    wt(5);
  endtask
  // ========================================
  // Transfers
  // address, command, low, high
  task automatic wr(input logic [7:0] adr, input logic [7:0] cmd, input logic [7:0] lo,
                    input logic [7:0] hi, input logic word, output logic [3:0] acks);
    logic [8:0] r;
    logic [31:0] q;
    q = {adr, cmd, lo, hi};
    acks = 4'h0;
    start_c();
    for (int i = 3; i >= (word ? 0 : 1); i--) begin
      bit9({q[i*8 +: 8], 1'b1}, r);
      acks[i] = !r[0];
    end
    stop_c();
  endtask
  task automatic rd(output logic [15:0] w);
    logic [8:0] r;
    start_c();
    bit9({8'h31, 1'b1}, r);
    bit9(9'h1FE, r);
    w[7:0] = r[8:1];
    bit9(9'h1FF, r);
    w[15:8] = r[8:1];
    stop_c();
  endtask
endmodule

//--- verification/testbench.sv
/*
  Self-checking bench for the regulation command bank.
  Assumes the host model for bus traffic and the constants of the design package.
*/
`timescale 1ns/10ps
module testbench;
  import psu_cmd_pkg::*;
  // ========================================
  // Signals and tables
  localparam int MS = 20;
  localparam int CVS [4] = '{300, 2400, 2500, 200};
  localparam int CCS [3] = '{64, 10, 200};
  localparam int RV [3] = '{1000, 1000, 700};
  localparam int RI [3] = '{64, 128, 160};
  localparam logic [1:0] TT [4] = '{2'd0, 2'd2, 2'd3, 2'd1};
  localparam logic [1:0] RR [4] = '{2'd1, 2'd3, 2'd1, 2'd2};
  logic CLK, RST_B, SCL, SDA_IN, SYS_READY, IS_SHORT, UV_COMPARE, sda_low;
  logic [7:0] AVG_CURRENT;
  logic [11:0] OUT_VOLTAGE;
  logic SDA_OUT, SDA_OE, CC_REG_EN, OVERLOAD, AUTO_RESTART, LATCH_OFF, UV_PROTECT_FORCE;
  logic [13:0] CV_TARGET;
  logic [7:0] CC_LIMIT;
  logic [6:0] CDC_OFFSET;
  region_e REGION;
  logic [31:0] seed = 32'h4a9f;
  int n_errors = 0, comparisons = 0, cycles = 0, ar_cnt = 0;
  // Open-drain wire with pull-up
  assign SDA_IN = !(sda_low | (SDA_OE & !SDA_OUT));
  always #5 CLK = ~CLK;
  psu_regulation_command_regs #(.MS_CYCLES(MS)) dut_u (.CLK, .RST_B, .SCL, .SDA_IN,
    .SDA_OUT, .SDA_OE, .SYS_READY, .AVG_CURRENT, .OUT_VOLTAGE, .IS_SHORT, .UV_COMPARE,
    .CV_TARGET, .CC_REG_EN, .CC_LIMIT, .CDC_OFFSET, .REGION, .OVERLOAD, .AUTO_RESTART,
    .LATCH_OFF, .UV_PROTECT_FORCE);
  host_model host_u (.clk(CLK), .sda(SDA_IN), .scl(SCL), .sda_low(sda_low));
  // ========================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Odd parity in the top bit
  function automatic logic [7:0] par7(input logic [6:0] v);
    return {~^v, v};
  endfunction
  function automatic logic [13:0] clampv(input int v, input int lo, input int hi);
    return 14'(v < lo ? lo : (v > hi ? hi : v));
  endfunction
  // Current threshold reached wins; otherwise power limit against the knee
  function automatic region_e exp_region(input int v, input int i, input int knee,
                                         input int cc);
    if (i >= cc) return REG_CC;
    if (knee >= 240 || v * i < knee * 1280) return REG_CV;
    return (v < knee * 10) ? REG_CC : REG_CP;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("Errors %0d, comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wr_word(input logic [7:0] cmd, input logic [13:0] v);
    logic [3:0] a;
    host_u.wr(8'h30, cmd, par7(v[6:0]), par7(v[13:7]), 1'b1, a);
    chk(16'(a), 16'h000F);
  endtask
  task automatic wr_byte(input logic [7:0] cmd, input logic [7:0] b);
    logic [3:0] a;
    host_u.wr(8'h30, cmd, b, 8'h00, 1'b0, a);
    chk(16'(a[3:1]), 16'h0007);
  endtask
  task automatic settle(input logic [11:0] v, input logic [7:0] i);
    OUT_VOLTAGE = v;
    AVG_CURRENT = i;
    repeat (4) @(negedge CLK);
  endtask
  task automatic do_reset();
    RST_B = 1'b0;
    repeat (4) @(negedge CLK);
    RST_B = 1'b1;
    repeat (4) @(negedge CLK);
  endtask
  // Overload from a clean start; n counts cycles to the response
  task automatic overload(input logic [1:0] t, input logic [1:0] r, output int n);
    AVG_CURRENT = 8'h00;
    wr_byte(CMD_PLT, {6'h00, t});
    wr_byte(CMD_OL_RESP, {6'h00, r});
    ar_cnt = 0;
    AVG_CURRENT = 8'hC8;
    n = 0;
    while (n < (8 << t) * MS + 40 && AUTO_RESTART !== 1'b1 && LATCH_OFF !== 1'b1) begin
      @(negedge CLK);
      n++;
    end
    repeat (20) @(negedge CLK);
  endtask
  // Hang guard: far above the expected run length; sampled off the launching edge
  always @(negedge CLK) begin
    cycles++;
    if (AUTO_RESTART === 1'b1) ar_cnt++;
    if (cycles == 40000) begin
      n_errors++;
      close_out();
    end
  end
  // ========================================
  // Main sequence
  initial begin
    int v, i, e, n, lim;
    logic [3:0] a;
    logic [15:0] w;
    CLK = 1'b0;
    RST_B = 1'b0;
    SYS_READY = 1'b1;
    IS_SHORT = 1'b0;
    UV_COMPARE = 1'b0;
    AVG_CURRENT = 8'h00;
    OUT_VOLTAGE = 12'h01F4;
    do_reset();
    chk(16'(CV_TARGET), 16'd500);
    chk(16'(CC_LIMIT), 16'd128);
    chk(16'({REGION, CDC_OFFSET, UV_PROTECT_FORCE, OVERLOAD, LATCH_OFF, SDA_OUT}), 16'h0000);
    // Ready flag at both levels before any other traffic
    for (int k = 0; k < 2; k++) begin
      SYS_READY = k[0];
      UV_COMPARE = !k[0];
      host_u.wr(8'h30, CMD_RD_PTR, PTR_STATUS, PTR_STATUS, 1'b1, a);
      host_u.rd(w);
      chk(16'({a, w[14], w[1]}), 16'({4'hF, k[0], !k[0]}));
    end
    // Setpoint corners, then random in range
    for (int k = 0; k < 8; k++) begin
      v = (k < 4) ? CVS[k] : 300 + int'(rnd() % 2101);
      e = clampv(v, 300, 2400);
      wr_word(CMD_CV, 14'(v));
      chk(16'(CV_TARGET), 16'(e));
    end
    // Refused traffic changes nothing
    host_u.wr(8'h30, CMD_CV, 8'h20, 8'h06, 1'b1, a);
    chk(16'({a[0], CV_TARGET}), 16'({1'b0, 14'(e)}));
    host_u.wr(8'h30, 8'h18, 8'h40, 8'h80, 1'b1, a);
    chk(16'({a[2], CC_LIMIT}), 16'h0080);
    host_u.wr(8'h32, CMD_CV, 8'h20, 8'h86, 1'b1, a);
    chk(16'({a[3], CV_TARGET}), 16'({1'b0, 14'(e)}));
    for (int k = 0; k < 3; k++) begin
      wr_word(CMD_CC, 14'(CCS[k]));
      chk(16'(CC_LIMIT), 16'(clampv(CCS[k], 25, 128)));
    end
    // Regions with knee at 8 V: table, then random loads
    wr_word(CMD_KNEE, 14'd80);
    for (int k = 0; k < 10; k++) begin
      v = (k < 3) ? RV[k] : 300 + int'(rnd() % 2101);
      i = (k < 3) ? RI[k] : int'(rnd() % 256);
      settle(12'(v), 8'(i));
      chk(16'(REGION), 16'(exp_region(v, i, 80, 128)));
    end
    wr_word(CMD_CC, 14'd64);
    settle(12'd2000, 8'd60);
    chk(16'(REGION), 16'(REG_CP));
    wr_word(CMD_KNEE, 14'd240);
    settle(12'd2000, 8'd60);
    chk(16'(REGION), 16'(REG_CV));
    settle(12'd500, 8'd128);
    // Compensation codes at full-scale current, then lighter loads
    for (int k = 0; k <= 12; k++) begin
      wr_byte(CMD_CDC, 8'(k));
      chk(16'(CDC_OFFSET), 16'(k * 5));
    end
    for (int k = 0; k < 2; k++) begin
      settle(12'd500, 8'(k * 64));
      chk(16'(CDC_OFFSET), 16'(k * 30));
    end
    IS_SHORT = 1'b1;
    settle(12'd500, 8'd128);
    chk(16'({CDC_OFFSET, CC_REG_EN}), 16'h0000);
    IS_SHORT = 1'b0;
    settle(12'd500, 8'd128);
    chk(16'({CDC_OFFSET, CC_REG_EN}), 16'h0079);
    // Voltage-only mode from reset defaults
    do_reset();
    wr_byte(CMD_VOLT_ONLY, 8'h01);
    chk(16'({UV_PROTECT_FORCE, CC_REG_EN}), 16'h0002);
    settle(12'd500, 8'd128);
    chk(16'(OVERLOAD), 16'h0000);
    ar_cnt = 0;
    settle(12'd500, 8'd200);
    chk(16'(OVERLOAD), 16'h0001);
    repeat (8 * MS + 40) @(negedge CLK);
    chk(16'({LATCH_OFF, 8'(ar_cnt)}), 16'h0000);
    // Every timer code and every response; latch-off last as it holds
    for (int k = 0; k < 4; k++) begin
      lim = (8 << TT[k]) * MS;
      overload(TT[k], RR[k], n);
      chk(16'(RR[k] == 2'd3 ? n == lim + 40 : n >= lim - 1 && n <= lim + 4), 16'h1);
      chk(16'({LATCH_OFF, 8'(ar_cnt)}), 16'({RR[k] == 2'd2, 8'(RR[k] == 2'd1)}));
    end
    settle(12'd500, 8'd0);
    chk(16'(LATCH_OFF), 16'h0001);
    do_reset();
    chk(16'(LATCH_OFF), 16'h0000);
    close_out();
  end
endmodule
